// File: design/mio_debounce.sv
// one input bit: two-flop synchroniser then stability counter
// assumes a raw asynchronous level on raw_in
`timescale 1ns/100ps
`default_nettype none
module mio_debounce
  import mio_pkg::*;
#(
  parameter int DEB_CYCLES = MIO_DEB_CYCLES
) (
  // clock and reset
  input  wire logic clk_sys_in,
  input  wire logic arst_n_in,
  // level
  input  wire logic raw_in,
  output logic      clean_out
);
  localparam int CW = $clog2(DEB_CYCLES + 1);
  initial begin
    if (DEB_CYCLES < 1) $error("debounce count must be positive");
  end
  logic          meta;
  logic          sync;
  logic [CW-1:0] cnt;

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta <= 1'b0;
      sync <= 1'b0;
    end else begin
      meta <= raw_in;
      sync <= meta;
    end
  end

  // a change must hold for the full count before it is passed on
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt       <= '0;
      clean_out <= 1'b0;
    end else if (sync == clean_out) begin
      cnt <= '0;
    end else if (cnt == CW'(DEB_CYCLES - 1)) begin
      cnt       <= '0;
      clean_out <= sync;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

  a_deb_stable: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    $changed(clean_out) |-> $past(sync) == clean_out)
    else $error("debounced level changed without input agreeing");
endmodule : mio_debounce
`default_nettype wire

// File: design/mio_pkg.sv
// constants for the machine io function logic
// assumes a 20 MHz system clock and active-low asynchronous reset
package mio_pkg;
  localparam int          MIO_CLK_HZ        = 20000000;
  localparam int          MIO_END_MS        = 200;
  localparam int          MIO_END_CYCLES    = MIO_CLK_HZ / 1000 * MIO_END_MS;
  localparam int          MIO_DEB_US        = 5000;
  localparam int          MIO_DEB_CYCLES    = MIO_CLK_HZ / 1000000 * MIO_DEB_US;
  localparam int          MIO_NUM_IN        = 16;
  localparam int          MIO_HOT_W         = 9;
  localparam logic [8:0]  MIO_HOT_NONE      = 9'h000;
  localparam logic [8:0]  MIO_HOT_EXP_OFS   = 9'h004;
  localparam int          MIO_BIT_MAIN      = 0;
  localparam int          MIO_BIT_EXP       = 4;
  localparam int          MIO_BIT_CORR_X    = 12;
  localparam int          MIO_BIT_CORR_Y    = 13;
  localparam int          MIO_BIT_CORR_Z    = 14;
  localparam int          MIO_BIT_AIR       = 15;
endpackage : mio_pkg

// File: design/mio_pulse.sv
// fixed-length pulse stretcher, retriggers on each start
// assumes start_in is a one-cycle pulse on the same clock
`timescale 1ns/100ps
`default_nettype none
module mio_pulse
  import mio_pkg::*;
#(
  parameter int PULSE_CYCLES = MIO_END_CYCLES
) (
  // clock and reset
  input  wire logic clk_sys_in,
  input  wire logic arst_n_in,
  // control
  input  wire logic start_in,
  output logic      pulse_out
);
  localparam int CW = $clog2(PULSE_CYCLES + 1);
  initial begin
    if (PULSE_CYCLES < 1) $error("pulse length must be positive");
  end
  logic [CW-1:0] remain;

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      remain    <= '0;
      pulse_out <= 1'b0;
    end else if (start_in) begin
      remain    <= CW'(PULSE_CYCLES - 1);
      pulse_out <= 1'b1;
    end else if (remain != '0) begin
      remain <= remain - 1'b1;
    end else begin
      pulse_out <= 1'b0;
    end
  end

  a_pulse_start: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    start_in |=> pulse_out)
    else $error("end pulse did not start");
  a_pulse_end: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    pulse_out && remain == '0 && !start_in |=> !pulse_out)
    else $error("end pulse overran its length");
endmodule : mio_pulse
`default_nettype wire

// File: design/mio_top.sv
// machine io function logic: input decode and status outputs
// assumes raw pins are asynchronous; machine state arrives on clk_sys_in
`timescale 1ns/100ps
`default_nettype none
module mio_top
  import mio_pkg::*;
#(
  parameter int DEB_CYCLES = MIO_DEB_CYCLES,
  parameter int END_CYCLES = MIO_END_CYCLES
) (
  // clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       arst_n_in,
  // raw input pins
  input  wire logic [3:0] main_inputs_in,
  input  wire logic [7:0] expansion_inputs_one_to_eight_in,
  input  wire logic       expansion_input_nine_in,
  input  wire logic       expansion_input_ten_in,
  input  wire logic       expansion_input_eleven_in,
  input  wire logic       air_pressure_in,
  input  wire logic       left_box_press_in,
  input  wire logic       right_box_press_in,
  // machine state from the controller
  input  wire logic       dual_y_en_in,
  input  wire logic       standby_in,
  input  wire logic       running_in,
  input  wire logic       paused_in,
  input  wire logic       abnormal_in,
  input  wire logic       process_done_in,
  input  wire logic [3:0] head_exec_in,
  input  wire logic       cylinder_exec_in,
  input  wire logic       cleaning_exec_in,
  // hotkey file selection
  output logic            hotkey_valid_out,
  output logic [8:0]      hotkey_code_out,
  output logic            file_select_out,
  // head correction requests
  output logic            correct_xyz_out,
  output logic            correct_pending_out,
  // status
  output logic            air_pressure_out,
  // indicator and actuator outputs
  output logic            ready_out,
  output logic            alarm_out,
  output logic            running_out,
  output logic            end_out,
  output logic [3:0]      feed_out,
  output logic            cylinder_out,
  output logic            cleaning_out,
  output logic            pause_out,
  output logic            left_ind_out,
  output logic            right_ind_out
);
  initial begin
    if (DEB_CYCLES < 1 || END_CYCLES < 1) $error("counts must be positive");
  end

  logic [MIO_NUM_IN-1:0] raw;
  logic [MIO_NUM_IN-1:0] clean;
  logic                  side_meta_l;
  logic                  side_meta_r;
  logic                  side_l;
  logic                  side_r;
  logic [8:0]            next_code;
  logic [8:0]            code_prev;

  assign raw = {air_pressure_in, expansion_input_eleven_in, expansion_input_ten_in,
                expansion_input_nine_in, expansion_inputs_one_to_eight_in,
                main_inputs_in};

  genvar gi;
  generate
    for (gi = 0; gi < MIO_NUM_IN; gi++) begin : g_in
      mio_debounce #(.DEB_CYCLES(DEB_CYCLES)) u_deb (
        .clk_sys_in (clk_sys_in),
        .arst_n_in  (arst_n_in),
        .raw_in     (raw[gi]),
        .clean_out  (clean[gi])
      );
    end
  endgenerate

  // main inputs win over the expansion pattern; lowest main input first
  always_comb begin
    next_code = MIO_HOT_NONE;
    if (clean[MIO_BIT_EXP +: 8] != 8'h00) begin
      next_code = {1'b0, clean[MIO_BIT_EXP +: 8]} + MIO_HOT_EXP_OFS;
    end
    for (int i = 3; i >= 0; i--) begin
      if (clean[MIO_BIT_MAIN + i]) begin
        next_code = 9'(i + 1);
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hotkey_code_out  <= MIO_HOT_NONE;
      hotkey_valid_out <= 1'b0;
      code_prev        <= MIO_HOT_NONE;
      file_select_out  <= 1'b0;
    end else begin
      hotkey_code_out  <= next_code;
      hotkey_valid_out <= (next_code != MIO_HOT_NONE);
      code_prev        <= next_code;
      // one select strobe per new nonzero code, held codes do not repeat
      file_select_out  <= (next_code != MIO_HOT_NONE) && (next_code != code_prev);
    end
  end

  // a lone axis request is held pending, never applied
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      correct_xyz_out     <= 1'b0;
      correct_pending_out <= 1'b0;
    end else begin
      correct_xyz_out <= clean[MIO_BIT_CORR_X] && clean[MIO_BIT_CORR_Y]
                         && clean[MIO_BIT_CORR_Z];
      correct_pending_out <= (clean[MIO_BIT_CORR_X] || clean[MIO_BIT_CORR_Y]
                             || clean[MIO_BIT_CORR_Z])
                             && !(clean[MIO_BIT_CORR_X] && clean[MIO_BIT_CORR_Y]
                             && clean[MIO_BIT_CORR_Z]);
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      air_pressure_out <= 1'b0;
    end else begin
      air_pressure_out <= clean[MIO_BIT_AIR];
    end
  end

  // button box presses are pins; no debounce needed for a lamp
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      side_meta_l <= 1'b0;
      side_meta_r <= 1'b0;
      side_l      <= 1'b0;
      side_r      <= 1'b0;
    end else begin
      side_meta_l <= left_box_press_in;
      side_meta_r <= right_box_press_in;
      side_l      <= side_meta_l;
      side_r      <= side_meta_r;
    end
  end

  // latched while dual_y_en_in is high: the lamp stays on the last side pressed; both lamps clear when it is low
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      left_ind_out  <= 1'b0;
      right_ind_out <= 1'b0;
    end else if (!dual_y_en_in) begin
      left_ind_out  <= 1'b0;
      right_ind_out <= 1'b0;
    end else if (side_l && !side_r) begin
      left_ind_out  <= 1'b1;
      right_ind_out <= 1'b0;
    end else if (side_r && !side_l) begin
      left_ind_out  <= 1'b0;
      right_ind_out <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ready_out    <= 1'b0;
      alarm_out    <= 1'b0;
      running_out  <= 1'b0;
      pause_out    <= 1'b0;
      feed_out     <= 4'h0;
      cylinder_out <= 1'b0;
      cleaning_out <= 1'b0;
    end else begin
      ready_out    <= standby_in && !running_in && !abnormal_in;
      alarm_out    <= abnormal_in;
      running_out  <= running_in;
      pause_out    <= paused_in;
      feed_out     <= head_exec_in;
      cylinder_out <= cylinder_exec_in;
      cleaning_out <= cleaning_exec_in;
    end
  end

  mio_pulse #(.PULSE_CYCLES(END_CYCLES)) u_end (
    .clk_sys_in (clk_sys_in),
    .arst_n_in  (arst_n_in),
    .start_in   (process_done_in),
    .pulse_out  (end_out)
  );

  a_ready_drop: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    running_in |=> !ready_out)
    else $error("ready stayed on while running");
  a_alarm_follow: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    ##1 alarm_out == $past(abnormal_in))
    else $error("alarm does not follow abnormal condition");
  a_run_follow: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    running_in ##1 running_in |=> running_out)
    else $error("running output dropped during motion");
  a_feed_heads: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    ##1 feed_out == $past(head_exec_in))
    else $error("feed outputs do not track head programs");
  a_cyl_clean: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    ##1 (cylinder_out == $past(cylinder_exec_in)
    && cleaning_out == $past(cleaning_exec_in)))
    else $error("cylinder or cleaning output wrong");
  a_pause_follow: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    ##1 pause_out == $past(paused_in))
    else $error("pause output wrong");
  a_main_hotkey: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    clean[MIO_BIT_MAIN] |=> hotkey_code_out == 9'h001)
    else $error("main input one did not give hotkey one");
  a_exp_hotkey: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    clean[MIO_BIT_MAIN +: 4] == 4'h0 && clean[MIO_BIT_EXP +: 8] != 8'h00
    |=> hotkey_code_out == {1'b0, $past(clean[MIO_BIT_EXP +: 8])} + MIO_HOT_EXP_OFS)
    else $error("expansion hotkey not value plus four");
  a_xyz_only: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    correct_xyz_out |-> $past(clean[MIO_BIT_CORR_X]) && $past(clean[MIO_BIT_CORR_Y])
    && $past(clean[MIO_BIT_CORR_Z]))
    else $error("correction applied without all three axes");
  a_end_length: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    process_done_in ##1 !process_done_in[*3] |-> end_out)
    else $error("end pulse too short");
endmodule : mio_top
`default_nettype wire

// File: testbench/mio_pins.sv
// model of the external buttons, sensors and side boxes wired to the raw pins
// assumes the bench sets the wanted levels on clk_sys_in
`timescale 1ns/100ps
`default_nettype none
module mio_pins (
  // clock
  input  wire logic       clk_sys_in,
  // wanted levels
  input  wire logic [3:0] want_main_in,
  input  wire logic [7:0] want_exp_in,
  input  wire logic [2:0] want_xyz_in,
  input  wire logic [2:0] want_misc_in,
  input  wire logic       bounce_in,
  // pins
  output logic [3:0]      main_out,
  output logic [7:0]      exp_out,
  output logic [2:0]      xyz_out,
  output logic [2:0]      misc_out
);
  // contact bounce inverts the main contacts while bounce_in is high
  always_ff @(posedge clk_sys_in) begin
    main_out <= want_main_in ^ {4{bounce_in}};
    exp_out  <= want_exp_in;
    xyz_out  <= want_xyz_in;
    misc_out <= want_misc_in;
  end
endmodule : mio_pins
`default_nettype wire

// File: testbench/testbench.sv
// self-checking bench for mio_top with a pin model
// assumes short debounce and end counts for run time
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
  $display("ERROR %0t got %h want %h", $time, a, b); end end
module testbench;
  import mio_pkg::*;
  localparam int DEB = 4;
  localparam int ENDC = 10;
  logic clk_sys_in = 1'b0, arst_n_in = 1'b0;
  logic [3:0] w_main = '0, head_exec_in = '0;
  logic [7:0] w_exp = '0;
  logic [2:0] w_xyz = '0, w_misc = '0;
  logic bounce = 1'b0, dual_y_en_in = 1'b0, standby_in = 1'b0, running_in = 1'b0;
  logic paused_in = 1'b0, abnormal_in = 1'b0, process_done_in = 1'b0;
  logic cylinder_exec_in = 1'b0, cleaning_exec_in = 1'b0;
  logic [3:0] main_inputs_in, feed_out;
  logic [7:0] exp_pins;
  logic [2:0] xyz, misc;
  logic [8:0] hotkey_code_out;
  logic hotkey_valid_out, file_select_out, correct_xyz_out, correct_pending_out;
  logic air_pressure_out, ready_out, alarm_out, running_out, end_out;
  logic cylinder_out, cleaning_out, pause_out, left_ind_out, right_ind_out;
  logic [31:0] seed = 32'h6b576f51;
  int miscompares = 0, checked = 0, sel, n;
  logic [31:0] r;
  always #25 clk_sys_in = ~clk_sys_in;
  mio_pins pins (.clk_sys_in, .want_main_in(w_main), .want_exp_in(w_exp),
    .want_xyz_in(w_xyz), .want_misc_in(w_misc), .bounce_in(bounce),
    .main_out(main_inputs_in), .exp_out(exp_pins), .xyz_out(xyz), .misc_out(misc));
  mio_top #(.DEB_CYCLES(DEB), .END_CYCLES(ENDC)) uut (.clk_sys_in, .arst_n_in,
    .main_inputs_in, .expansion_inputs_one_to_eight_in(exp_pins),
    .expansion_input_nine_in(xyz[0]), .expansion_input_ten_in(xyz[1]),
    .expansion_input_eleven_in(xyz[2]), .air_pressure_in(misc[2]),
    .left_box_press_in(misc[1]), .right_box_press_in(misc[0]), .dual_y_en_in,
    .standby_in, .running_in, .paused_in, .abnormal_in, .process_done_in,
    .head_exec_in, .cylinder_exec_in, .cleaning_exec_in, .hotkey_valid_out,
    .hotkey_code_out, .file_select_out, .correct_xyz_out, .correct_pending_out,
    .air_pressure_out, .ready_out, .alarm_out, .running_out, .end_out, .feed_out,
    .cylinder_out, .cleaning_out, .pause_out, .left_ind_out, .right_ind_out);
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  // lowest main input wins over the expansion pattern
  function automatic logic [8:0] exp_code(input logic [3:0] m, input logic [7:0] e);
    for (int i = 0; i < 4; i++) if (m[i]) return 9'(i + 1);
    return (e == 8'h00) ? MIO_HOT_NONE : {1'b0, e} + MIO_HOT_EXP_OFS;
  endfunction : exp_code
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
  endtask : cyc
  task automatic end_of_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  task automatic set_in(input logic [3:0] m, input logic [7:0] e);
    @(posedge clk_sys_in);
    w_main <= m;
    w_exp <= e;
  endtask : set_in
  // bounded wait for a code, counting file selection pulses on the way
  task automatic wait_code(input logic [8:0] want);
    int k;
    k = 0;
    sel = 0;
    // first look is at a negedge, never in the edge that launches the code
    do begin
      @(negedge clk_sys_in);
      if (file_select_out === 1'b1) sel++;
      k++;
    end while (hotkey_code_out !== want && k < 40);
    if (hotkey_code_out !== want) begin
      miscompares++;
      $display("ERROR %0t hotkey wait ran out", $time);
      end_of_test();
    end
  endtask : wait_code
  initial begin
    repeat (2) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      set_in(4'h1 << i, 8'h00);
      wait_code(exp_code(4'h1 << i, 8'h00));
      `CHK(hotkey_valid_out, 1'b1)
      `CHK(sel, 1)
      cyc(1);
      `CHK(file_select_out, 1'b0)
      set_in(4'h0, 8'h00);
      wait_code(MIO_HOT_NONE);
    end
    set_in(4'h6, 8'h55);
    wait_code(exp_code(4'h6, 8'h55));
    `CHK(hotkey_code_out, 9'h002)
    for (int i = 0; i < 8; i++) begin
      r = (i == 0) ? 32'h1 : (i == 1) ? 32'hff : xs();
      if (r[7:0] == 8'h00) r[0] = 1'b1;
      set_in(4'h0, r[7:0]);
      wait_code(exp_code(4'h0, r[7:0]));
      `CHK(hotkey_valid_out, 1'b1)
    end
    set_in(4'h0, 8'h00);
    wait_code(MIO_HOT_NONE);
    // a contact flicker shorter than the debounce time must not select a file
    // longest refused flicker: one cycle short of the debounce count
    @(posedge clk_sys_in) bounce <= 1'b1;
    repeat (DEB - 1) @(posedge clk_sys_in);
    bounce <= 1'b0;
    n = 0;
    repeat (14) begin
      @(negedge clk_sys_in);
      if (hotkey_valid_out !== 1'b0 || file_select_out !== 1'b0) n++;
    end
    `CHK(n, 0)
    `CHK(hotkey_code_out, MIO_HOT_NONE)
    for (int j = 0; j < 8; j++) begin
      @(posedge clk_sys_in);
      w_xyz <= 3'(j);
      w_misc <= {j[0], 2'b00};
      cyc(12);
      `CHK(correct_xyz_out, (j == 7))
      `CHK(correct_pending_out, (j != 0 && j != 7))
      `CHK(air_pressure_out, j[0])
    end
    for (int k = 0; k < 24; k++) begin
      r = (k == 0) ? 32'h1 : xs();
      @(posedge clk_sys_in);
      {cleaning_exec_in, cylinder_exec_in, head_exec_in} <= r[9:4];
      {abnormal_in, paused_in, running_in, standby_in} <= r[3:0];
      cyc(2);
      `CHK(ready_out, r[0] & ~r[1] & ~r[3])
      `CHK(alarm_out, r[3])
      `CHK(running_out, r[1])
      `CHK(pause_out, r[2])
      `CHK(feed_out, r[7:4])
      `CHK(cylinder_out, r[8])
      `CHK(cleaning_out, r[9])
    end
    @(posedge clk_sys_in) process_done_in <= 1'b1;
    @(posedge clk_sys_in) process_done_in <= 1'b0;
    n = 0;
    repeat (30) begin
      @(negedge clk_sys_in);
      if (end_out === 1'b1) n++;
    end
    `CHK(n, ENDC)
    @(posedge clk_sys_in) w_misc <= 3'b010;
    cyc(6);
    `CHK({left_ind_out, right_ind_out}, 2'b00)
    @(posedge clk_sys_in) dual_y_en_in <= 1'b1;
    cyc(6);
    `CHK({left_ind_out, right_ind_out}, 2'b10)
    @(posedge clk_sys_in) w_misc <= 3'b001;
    cyc(6);
    `CHK({left_ind_out, right_ind_out}, 2'b01)
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
